// ---- cell_fifo.v ----
`timescale 1ns/1ps
module cell_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data,
  // level
  output wire [AW:0] level
);
  // ==========================================
  // storage
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  reg out_v_q;
  wire push;
  wire pop;
  wire load;
  wire [31:0] level_w;
  assign level_w = {{(31-AW){1'b0}}, cnt_q};
  assign in_ready = (level_w != DEPTH);
  assign push = in_valid && in_ready;
  assign load = (cnt_q != {(AW+1){1'b0}}) && (!out_v_q || out_ready);
  assign pop = load;
  assign out_valid = out_v_q;
  assign level = cnt_q;
  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      out_v_q <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
        out_data <= mem[rd_q];
        out_v_q <= 1'b1;
      end else if (out_ready) begin
        out_v_q <= 1'b0;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ---- phy_peer.sv ----
`timescale 1ns/1ps
// ====
// far-side phy model, bit 3 is line 31
module phy_peer (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // mode and bench commands
  input wire [2:0] mode,
  input wire [2:0] cmd,
  // levels toward the pins
  output reg [3:0] drv
);
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      drv <= 4'h0;
    end else begin
      case (mode)
        3'h1, 3'h3: drv <= {1'b0, cmd[0], 2'h0};
        3'h2: drv <= {cmd[0], 2'h0, cmd[1]};
        3'h4: drv <= {cmd[0], cmd[1], 2'h0};
        default: drv <= 4'h0;
      endcase
    end
  end
endmodule

// ---- port_a_mux.v ----
`timescale 1ns/1ps
`include "port_a_mux_defs.vh"
module port_a_mux #(
  parameter FIFO_DEPTH = `FIFO_DEPTH,
  parameter FIFO_AW = 2
) (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // protocol select
  input wire [2:0] proto_sel,
  // general-purpose io for the four lines, bit 0 is line 28
  input wire [3:0] gpio_out,
  input wire [3:0] gpio_dir,
  output reg [3:0] gpio_in,
  // pins, output enable low while driving
  input wire port_a_bit31_i,
  output reg port_a_bit31_o,
  output reg port_a_bit31_oe_n,
  input wire port_a_bit30_i,
  output reg port_a_bit30_o,
  output reg port_a_bit30_oe_n,
  input wire port_a_bit29_i,
  output reg port_a_bit29_o,
  output reg port_a_bit29_oe_n,
  input wire port_a_bit28_i,
  output reg port_a_bit28_o,
  output reg port_a_bit28_oe_n,
  // transmit cell byte stream into the fifo
  input wire tx_cell_valid,
  output wire tx_cell_ready,
  input wire [7:0] tx_cell_data,
  input wire tx_cell_first,
  // transmit data toward the link
  output reg [7:0] tx_data,
  // slave side room for a whole cell
  input wire slave_room,
  output reg slave_tx_enable,
  // receive control
  input wire rx_want,
  output reg rx_sample,
  // mii controller
  input wire mii_tx_active,
  input wire mii_tx_error,
  output reg mii_collision,
  output reg mii_carrier,
  // hdlc controller
  input wire hdlc_request,
  input wire clear_to_send_n,
  output reg hdlc_granted,
  // link status
  output reg peer_cell_avail
);
  // ==========================================
  // mode decode
  function is_cell_master;
    input [2:0] p;
    begin
      is_cell_master = (p == `PROTO_CELL_MASTER) || (p == `PROTO_CELL_MPHY);
    end
  endfunction

  wire master_mode;
  wire slave_mode;
  wire mii_mode;
  wire hdlc_mode;
  assign master_mode = is_cell_master(proto_sel);
  assign slave_mode = (proto_sel == `PROTO_CELL_SLAVE);
  assign mii_mode = (proto_sel == `PROTO_MII);
  assign hdlc_mode = (proto_sel == `PROTO_HDLC);

  // ==========================================
  // transmit fifo
  wire f_valid;
  wire f_ready;
  wire [8:0] f_data;
  cell_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(tx_cell_valid),
    .in_ready(tx_cell_ready),
    .in_data({tx_cell_first, tx_cell_data}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data),
    .level()
  );

  // ==========================================
  // cell transmit sequencer
  localparam ST_WAIT = 2'd0;
  localparam ST_DATA = 2'd1;
  localparam ST_IDLE = 2'd2;

  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [5:0] cnt_q;
  reg [5:0] cnt_d;
  reg tx_en_q;
  reg tx_soc_q;
  reg peer_clav;
  reg send_byte;
  reg take_fifo;

  // a cell only starts once the peer has room; queued data wins over idle
  always @* begin
    st_d = st_q;
    cnt_d = cnt_q;
    send_byte = 1'b0;
    take_fifo = 1'b0;
    case (st_q)
      ST_WAIT: begin
        if (master_mode && peer_clav) begin
          cnt_d = `CELL_FIRST;
          if (f_valid && f_data[`CELL_FLAG]) begin
            st_d = ST_DATA;
          end else begin
            st_d = ST_IDLE;
          end
        end
      end
      ST_DATA: begin
        if (f_valid) begin
          send_byte = 1'b1;
          take_fifo = 1'b1;
          cnt_d = cnt_q + 6'd1;
          if (cnt_q == `CELL_LAST) begin
            st_d = ST_WAIT;
          end
        end
      end
      ST_IDLE: begin
        send_byte = 1'b1;
        cnt_d = cnt_q + 6'd1;
        if (cnt_q == `CELL_LAST) begin
          st_d = ST_WAIT;
        end
      end
      default: begin
        st_d = ST_WAIT;
      end
    endcase
    if (!master_mode) begin
      st_d = ST_WAIT;
    end
  end

  // drop stray bytes that do not begin a cell while waiting
  assign f_ready = take_fifo || (st_q == ST_WAIT && f_valid && !f_data[`CELL_FLAG]);

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= ST_WAIT;
      cnt_q <= 6'd0;
      tx_en_q <= 1'b0;
      tx_soc_q <= 1'b0;
      tx_data <= `IDLE_BYTE;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      tx_en_q <= send_byte;
      tx_soc_q <= send_byte && (cnt_q == `CELL_FIRST);
      if (send_byte) begin
        if (st_q == ST_DATA) begin
          tx_data <= f_data[7:0];
        end else if (cnt_q == `CELL_FIRST) begin
          tx_data <= `IDLE_HDR;
        end else begin
          tx_data <= `IDLE_BYTE;
        end
      end
    end
  end

  // ==========================================
  // receive enable
  reg rx_en_q;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_en_q <= 1'b0;
      rx_sample <= 1'b0;
    end else begin
      rx_en_q <= master_mode && rx_want;
      // master sample slot follows an enable cycle only; in slave mode it follows line 28
      rx_sample <= master_mode ? rx_en_q : (slave_mode && port_a_bit28_i);
    end
  end

  // ==========================================
  // mii transmit and line status
  reg mii_en_q;
  reg mii_er_q;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mii_en_q <= 1'b0;
      mii_er_q <= 1'b0;
      mii_collision <= 1'b0;
      mii_carrier <= 1'b0;
    end else begin
      mii_en_q <= mii_mode && mii_tx_active;
      mii_er_q <= mii_mode && mii_tx_active && mii_tx_error;
      mii_collision <= mii_mode && port_a_bit31_i;
      mii_carrier <= mii_mode && port_a_bit30_i;
    end
  end

  // ==========================================
  // hdlc request-to-send
  reg rts_n_q;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rts_n_q <= 1'b1;
      hdlc_granted <= 1'b0;
    end else begin
      rts_n_q <= !(hdlc_mode && hdlc_request);
      hdlc_granted <= hdlc_mode && !rts_n_q && !clear_to_send_n;
    end
  end

  // ==========================================
  // cell handshakes in and pin sampling
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slave_tx_enable <= 1'b0;
      peer_cell_avail <= 1'b0;
      gpio_in <= 4'h0;
    end else begin
      slave_tx_enable <= slave_mode && port_a_bit31_i;
      peer_cell_avail <= master_mode && port_a_bit30_i;
      gpio_in <= {port_a_bit31_i, port_a_bit30_i, port_a_bit29_i, port_a_bit28_i};
    end
  end

  always @* begin
    peer_clav = port_a_bit30_i;
  end

  // ==========================================
  // pin routing
  always @* begin
    port_a_bit31_o = gpio_out[3];
    port_a_bit31_oe_n = !gpio_dir[3];
    port_a_bit30_o = gpio_out[2];
    port_a_bit30_oe_n = !gpio_dir[2];
    port_a_bit29_o = gpio_out[1];
    port_a_bit29_oe_n = !gpio_dir[1];
    port_a_bit28_o = gpio_out[0];
    port_a_bit28_oe_n = !gpio_dir[0];
    case (proto_sel)
      `PROTO_CELL_MASTER, `PROTO_CELL_MPHY: begin
        port_a_bit31_o = tx_en_q;
        port_a_bit31_oe_n = 1'b0;
        port_a_bit30_o = 1'b0;
        port_a_bit30_oe_n = 1'b1;
        port_a_bit29_o = tx_soc_q;
        port_a_bit29_oe_n = 1'b0;
        port_a_bit28_o = rx_en_q;
        port_a_bit28_oe_n = 1'b0;
      end
      `PROTO_CELL_SLAVE: begin
        port_a_bit31_o = 1'b0;
        port_a_bit31_oe_n = 1'b1;
        port_a_bit30_o = slave_room;
        port_a_bit30_oe_n = 1'b0;
        port_a_bit28_o = 1'b0;
        port_a_bit28_oe_n = 1'b1;
      end
      `PROTO_MII: begin
        port_a_bit31_o = 1'b0;
        port_a_bit31_oe_n = 1'b1;
        port_a_bit30_o = 1'b0;
        port_a_bit30_oe_n = 1'b1;
        port_a_bit29_o = mii_er_q;
        port_a_bit29_oe_n = 1'b0;
        port_a_bit28_o = mii_en_q;
        port_a_bit28_oe_n = 1'b0;
      end
      `PROTO_HDLC: begin
        port_a_bit30_o = rts_n_q;
        port_a_bit30_oe_n = 1'b0;
      end
      default: begin
        port_a_bit31_oe_n = !gpio_dir[3];
      end
    endcase
  end
endmodule

// ---- port_a_mux_assertions.sv ----
`timescale 1ns/1ps
// ====
// port line checker
module port_a_mux_assertions (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // watched ports
  input wire [2:0] proto_sel,
  input wire port_a_bit31_o,
  input wire port_a_bit31_oe_n,
  input wire port_a_bit30_o,
  input wire port_a_bit30_oe_n,
  input wire port_a_bit29_o,
  input wire port_a_bit29_oe_n,
  input wire port_a_bit28_o,
  input wire rx_sample,
  input wire slave_room,
  input wire hdlc_request,
  input wire mii_tx_active
);
  localparam int CELL = 53;
  reg ok_q;
  reg [2:0] mode_q;
  reg [5:0] cnt_q;
  wire mst = (proto_sel == 3'h1) || (proto_sel == 3'h3);
  wire ok = ok_q && (mode_q == proto_sel);
  wire en = mst && port_a_bit31_o;
  wire soc = en && port_a_bit29_o;
  // ====
  // same-mode tracker and cell byte counter
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ok_q <= 1'b0;
      mode_q <= 3'h0;
      cnt_q <= 6'h0;
    end else begin
      ok_q <= 1'b1;
      mode_q <= proto_sel;
      cnt_q <= !mst ? 6'h0 : soc ? 6'h1 : en ? cnt_q + 6'h1 : cnt_q;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ====
  // assertions
  AST_MASTER_DIR: assert property (
    mst |-> !port_a_bit31_oe_n && !port_a_bit29_oe_n && port_a_bit30_oe_n)
    else $error("master pin directions wrong");
  AST_SOC_EN: assert property (
    mst && port_a_bit29_o |-> port_a_bit31_o) else $error("start of cell without enable");
  AST_CELL_LEN: assert property (
    en |-> (port_a_bit29_o ? (cnt_q == 0 || cnt_q == CELL) : (cnt_q != 0 && cnt_q < CELL)))
    else $error("cell length not 53");
  AST_RX_NEXT: assert property (
    ok && mst && port_a_bit28_o |=> rx_sample) else $error("no sample after receive enable");
  AST_RX_AFTER: assert property (
    ok && mst && rx_sample |-> $past(port_a_bit28_o)) else $error("sample without enable");
  AST_SLAVE_CLAV: assert property (
    proto_sel == 3'h2 |-> port_a_bit30_o == slave_room && !port_a_bit30_oe_n)
    else $error("slave cell-available wrong");
  AST_HDLC_RTS: assert property (
    ok && proto_sel == 3'h5 |-> port_a_bit30_o == !$past(hdlc_request))
    else $error("request-to-send wrong");
  AST_MII_TXEN: assert property (
    ok && proto_sel == 3'h4 |-> port_a_bit28_o == $past(mii_tx_active))
    else $error("mii transmit enable wrong");
  cover property (soc);
  cover property (ok && mst && port_a_bit28_o);
  cover property (proto_sel == 3'h2 && slave_room);
endmodule

bind port_a_mux port_a_mux_assertions i_chk (
  .clk_sys(clk_sys), .rst(rst), .proto_sel(proto_sel),
  .port_a_bit31_o(port_a_bit31_o), .port_a_bit31_oe_n(port_a_bit31_oe_n),
  .port_a_bit30_o(port_a_bit30_o), .port_a_bit30_oe_n(port_a_bit30_oe_n),
  .port_a_bit29_o(port_a_bit29_o), .port_a_bit29_oe_n(port_a_bit29_oe_n),
  .port_a_bit28_o(port_a_bit28_o), .rx_sample(rx_sample), .slave_room(slave_room),
  .hdlc_request(hdlc_request), .mii_tx_active(mii_tx_active)
);

// ---- port_a_mux_bench.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
// ====
// bench for the port line mux
module port_a_mux_bench;
  logic clk_sys = 1'b0, rst = 1'b1, tx_cell_valid = 1'b0, tx_cell_first = 1'b0;
  logic slave_room = 1'b0, rx_want = 1'b0, mii_tx_active = 1'b0, mii_tx_error = 1'b0;
  logic hdlc_request = 1'b0, clear_to_send_n = 1'b1;
  logic [2:0] proto_sel = 3'h0, cmd = 3'h0;
  logic [3:0] gpio_out = 4'hf, gpio_dir = 4'h5;
  logic [7:0] tx_cell_data = 8'h00;
  logic [7:0] c [53];
  int bad_count = 0;
  int n_checks = 0;
  wire [3:0] gpio_in, drv;
  wire [7:0] tx_data;
  wire tx_cell_ready, slave_tx_enable, rx_sample, mii_collision, mii_carrier;
  wire hdlc_granted, peer_cell_avail, port_a_bit31_o, port_a_bit30_o;
  wire port_a_bit29_o, port_a_bit28_o, port_a_bit31_oe_n, port_a_bit30_oe_n;
  wire port_a_bit29_oe_n, port_a_bit28_oe_n;
  wire [3:0] oe_n = {port_a_bit31_oe_n, port_a_bit30_oe_n, port_a_bit29_oe_n,
    port_a_bit28_oe_n};
  wire [3:0] pin_o = {port_a_bit31_o, port_a_bit30_o, port_a_bit29_o, port_a_bit28_o};
  wire [3:0] pin = (~oe_n & pin_o) | (oe_n & drv);
  wire port_a_bit31_i = pin[3];
  wire port_a_bit30_i = pin[2];
  wire port_a_bit29_i = pin[1];
  wire port_a_bit28_i = pin[0];
  port_a_mux i_dut (
    .clk_sys(clk_sys), .rst(rst), .proto_sel(proto_sel), .gpio_out(gpio_out),
    .gpio_dir(gpio_dir), .gpio_in(gpio_in),
    .port_a_bit31_i(port_a_bit31_i), .port_a_bit31_o(port_a_bit31_o),
    .port_a_bit31_oe_n(port_a_bit31_oe_n),
    .port_a_bit30_i(port_a_bit30_i), .port_a_bit30_o(port_a_bit30_o),
    .port_a_bit30_oe_n(port_a_bit30_oe_n),
    .port_a_bit29_i(port_a_bit29_i), .port_a_bit29_o(port_a_bit29_o),
    .port_a_bit29_oe_n(port_a_bit29_oe_n),
    .port_a_bit28_i(port_a_bit28_i), .port_a_bit28_o(port_a_bit28_o),
    .port_a_bit28_oe_n(port_a_bit28_oe_n),
    .tx_cell_valid(tx_cell_valid), .tx_cell_ready(tx_cell_ready),
    .tx_cell_data(tx_cell_data), .tx_cell_first(tx_cell_first), .tx_data(tx_data),
    .slave_room(slave_room), .slave_tx_enable(slave_tx_enable), .rx_want(rx_want),
    .rx_sample(rx_sample), .mii_tx_active(mii_tx_active), .mii_tx_error(mii_tx_error),
    .mii_collision(mii_collision), .mii_carrier(mii_carrier),
    .hdlc_request(hdlc_request), .clear_to_send_n(clear_to_send_n),
    .hdlc_granted(hdlc_granted), .peer_cell_avail(peer_cell_avail)
  );
  phy_peer i_peer (.clk_sys, .rst, .mode(proto_sel), .cmd, .drv);
  initial forever #2 clk_sys = ~clk_sys;
  // ====
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic get_cell;
    int k = 0;
    int n = 0;
    while (!(pin[3] && pin[1]) && k < 300) begin
      tick(1);
      k++;
    end
    while (n < 53 && k < 900) begin
      if (pin[3]) begin
        c[n] = tx_data;
        n++;
      end
      tick(1);
      k++;
    end
    `CHK("cell_count", 53, n)
  endtask
  task push_cell;
    int i;
    @(posedge clk_sys);
    for (i = 0; i < 53; i++) begin
      tx_cell_valid <= 1'b1;
      tx_cell_data <= 8'ha0 + i[7:0];
      tx_cell_first <= (i == 0);
      @(posedge clk_sys iff tx_cell_ready);
    end
    tx_cell_valid <= 1'b0;
  endtask
  task conclude;
    if (bad_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ====
  // scenarios
  task t_master(input logic [2:0] m);
    int i;
    @(posedge clk_sys);
    rst <= 1'b1;
    proto_sel <= m;
    cmd <= 3'h0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    fork push_cell; join_none
    tick(12);
    `CHK("fifo_ready", 1'b0, tx_cell_ready)
    @(posedge clk_sys);
    cmd <= 3'h1;
    tick(1);
    get_cell;
    for (i = 0; i < 53; i++) `CHK("cell", 8'ha0 + i[7:0], c[i])
    `CHK("clav", 1'b1, peer_cell_avail)
    get_cell;
    `CHK("idle", 16'h0100, {c[0], c[52]})
  endtask
  task t_rx;
    @(posedge clk_sys);
    rx_want <= 1'b1;
    @(posedge clk_sys);
    rx_want <= 1'b0;
    #1;
    `CHK("rx_enable", 1'b1, pin[0])
    tick(1);
    `CHK("rx_sample", 2'h2, {rx_sample, pin[0]})
    tick(1);
    `CHK("rx_end", 1'b0, rx_sample)
  endtask
  task t_slave;
    @(posedge clk_sys);
    proto_sel <= 3'h2;
    slave_room <= 1'b1;
    cmd <= 3'h3;
    tick(4);
    `CHK("slave_dir", 2'h2, {oe_n[3], oe_n[2]})
    `CHK("slave", 3'h7, {pin[2], slave_tx_enable, rx_sample})
    @(posedge clk_sys);
    slave_room <= 1'b0;
    tick(1);
    `CHK("slave_clav", 1'b0, pin[2])
  endtask
  task t_mii;
    @(posedge clk_sys);
    proto_sel <= 3'h4;
    mii_tx_active <= 1'b1;
    mii_tx_error <= 1'b1;
    cmd <= 3'h3;
    tick(3);
    `CHK("mii", 4'hf, {pin[1:0], mii_collision, mii_carrier})
    @(posedge clk_sys);
    mii_tx_error <= 1'b0;
    cmd <= 3'h2;
    tick(3);
    `CHK("mii_part", 4'h5, {pin[1:0], mii_collision, mii_carrier})
  endtask
  task t_hdlc;
    @(posedge clk_sys);
    proto_sel <= 3'h5;
    hdlc_request <= 1'b1;
    tick(3);
    `CHK("rts", 2'h0, {pin[2], hdlc_granted})
    @(posedge clk_sys);
    clear_to_send_n <= 1'b0;
    tick(2);
    `CHK("granted", 2'h1, {pin[2], hdlc_granted})
    @(posedge clk_sys);
    hdlc_request <= 1'b0;
    tick(2);
    `CHK("rts_off", 1'b1, pin[2])
  endtask
  task t_gpio;
    tick(3);
    `CHK("gpio_oe", 4'ha, oe_n)
    `CHK("gpio_in", 4'h5, gpio_in)
  endtask
  // ====
  // main sequence and watchdog
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_gpio;
    t_master(3'h1);
    t_rx;
    t_slave;
    t_mii;
    t_hdlc;
    t_master(3'h3);
    conclude;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    conclude;
  end
endmodule

// ---- port_a_mux_defs.vh ----
`ifndef PORT_A_MUX_DEFS_VH
`define PORT_A_MUX_DEFS_VH
// protocol select codes
`define PROTO_GPIO 3'h0
`define PROTO_CELL_MASTER 3'h1
`define PROTO_CELL_SLAVE 3'h2
`define PROTO_CELL_MPHY 3'h3
`define PROTO_MII 3'h4
`define PROTO_HDLC 3'h5
// cell framing
`define CELL_BYTES 6'd53
`define CELL_LAST 6'd52
`define CELL_FIRST 6'd0
`define CELL_FLAG 8
`define IDLE_BYTE 8'h00
`define IDLE_HDR 8'h01
// fifo
`define FIFO_DEPTH 4
`define FIFO_WIDTH 9
`endif
